// ==== hdl/tbpwm_pkg.sv ====
/*
  Shared constants and helpers for the dual 10-bit PWM block: the register
  map, field positions, reset values, prescale encodings and the bus states.
  Assumes a 32-bit Avalon-MM register bus with byte addresses.
*/
package tbpwm_pkg;

  // Register byte offsets, one aligned word per register.
  localparam logic [7:0] TBPWM_CH5_CONTROL_OFS   = 8'h00;
  localparam logic [7:0] TBPWM_CH5_DUTY_HIGH_OFS = 8'h04;
  localparam logic [7:0] TBPWM_CH5_DUTY_LOW_OFS  = 8'h08;
  localparam logic [7:0] TBPWM_CH6_CONTROL_OFS   = 8'h0C;
  localparam logic [7:0] TBPWM_CH6_DUTY_HIGH_OFS = 8'h10;
  localparam logic [7:0] TBPWM_CH6_DUTY_LOW_OFS  = 8'h14;
  localparam logic [7:0] TBPWM_TIMER_CONTROL_OFS = 8'h18;
  localparam logic [7:0] TBPWM_PERIOD_OFS        = 8'h1C;
  localparam logic [7:0] TBPWM_TIMER_COUNT_OFS   = 8'h20;
  localparam logic [7:0] TBPWM_STATUS_OFS        = 8'h24;

  // Field positions in the channel control register.
  localparam int TBPWM_CTRL_EN_BIT  = 7;
  localparam int TBPWM_CTRL_OUT_BIT = 5;
  localparam int TBPWM_CTRL_POL_BIT = 4;

  // Field positions in the duty low register and the timer registers.
  localparam int TBPWM_DUTY_LOW_MSB  = 7;
  localparam int TBPWM_DUTY_LOW_LSB  = 6;
  localparam int TBPWM_TIMER_ON_BIT  = 2;
  localparam int TBPWM_PRESCALE_MSB  = 1;
  localparam int TBPWM_MATCH_BIT     = 0;

  // Reset values of the state that has one.
  localparam logic [7:0] TBPWM_CTRL_RESET   = 8'h00;
  localparam logic [7:0] TBPWM_PERIOD_RESET = 8'hFF;
  localparam logic [7:0] TBPWM_COUNT_RESET  = 8'h00;
  localparam logic [5:0] TBPWM_PRESC_RESET  = 6'h00;
  localparam logic [9:0] TBPWM_DUTY_RESET   = 10'h000;

  // Last prescaler count of one timer step for each ratio.
  localparam logic [5:0] TBPWM_LAST_PRE1  = 6'h03;
  localparam logic [5:0] TBPWM_LAST_PRE4  = 6'h0F;
  localparam logic [5:0] TBPWM_LAST_PRE16 = 6'h3F;

  // Prescale selection codes.
  typedef enum logic [1:0] {
    TBPWM_PRE1  = 2'b00,
    TBPWM_PRE4  = 2'b01,
    TBPWM_PRE16 = 2'b10
  } tbpwm_prescale_t;

  // Bus slave states.
  typedef enum logic [0:0] {
    TBPWM_BUS_IDLE = 1'b0,
    TBPWM_BUS_ACK  = 1'b1
  } tbpwm_bus_state_t;

  // Joins the high and low duty registers into the 10-bit duty value.
  function automatic logic [9:0] tbpwm_duty_join(input logic [7:0] high, input logic [1:0] low);
    tbpwm_duty_join = {high, low};
  endfunction

  // Formats a channel control register for reading.
  function automatic logic [7:0] tbpwm_ctrl_word(input logic en, input logic lvl,
                                                 input logic pol);
    logic [7:0] w;
    w = 8'h00;
    w[TBPWM_CTRL_EN_BIT]  = en;
    w[TBPWM_CTRL_OUT_BIT] = lvl;
    w[TBPWM_CTRL_POL_BIT] = pol;
    tbpwm_ctrl_word = w;
  endfunction

endpackage

// ==== hdl/tbpwm_channel.sv ====
/*
  One PWM channel: the buffered duty value, the compare against the shared
  10-bit time base and the polarity stage. Assumes the time base, period and
  load strobe come from the shared period timer on the same clock.
*/
`timescale 1ns/100ps
module tbpwm_channel (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst,
  // Settings from the register file
  input  wire logic       enable,
  input  wire logic       polarity,
  input  wire logic [9:0] duty_value,
  // Shared period timer
  input  wire logic       load_duty,
  input  wire logic [9:0] time_base,
  input  wire logic [7:0] period_register,
  // Channel output
  output logic            pwm_out
);

  logic [9:0]  duty_buf;
  logic [9:0]  next_duty_buf;
  logic        next_pwm_out;
  logic [10:0] span;
  logic        over_period;
  logic        active;

  // Next buffer and output level.
  always_comb begin
    next_duty_buf = duty_buf;
    if (load_duty) begin
      next_duty_buf = duty_value;
    end
    span        = {1'b0, period_register, 2'b00} + 11'h004;
    over_period = {1'b0, duty_buf} > span;
    active      = time_base < duty_buf;
    if (!enable) begin
      next_pwm_out = polarity;
    end else if (over_period) begin
      next_pwm_out = pwm_out;
    end else begin
      next_pwm_out = polarity ^ active;
    end
  end

  // Registers of the channel.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      duty_buf <= tbpwm_pkg::TBPWM_DUTY_RESET;
      pwm_out  <= 1'b0;
    end else begin
      duty_buf <= next_duty_buf;
      pwm_out  <= next_pwm_out;
    end
  end

endmodule

// ==== hdl/tbpwm_top.sv ====
/*
  Two 10-bit PWM channels sharing one 8-bit period timer with a 1, 4 or 16
  prescaler, behind an Avalon-MM slave with waitrequest. Assumes a single
  50 MHz core clock and an asynchronous active-high reset from the system.
*/
// Design decisions made here: the placing of the registers and the Avalon-MM slave port.
// Operation
// - Duty high register holds duty bits nine to two, read and write.
// - Duty low bits seven and six hold duty bits one and zero.
// - Unused register bits ignore writes and read as zero.
// - Duty registers are not cleared by reset; contents start unknown.
// - Period register sets resolution; 0xFF gives ten bits.
// - Prescale 1, 4 or 16; period is 4 times period plus one, scaled.
// - New duty value takes effect when timer count equals period.
// - Time base is timer count plus two clock or prescaler bits.
// - Control has enable, read-only output level and polarity bits.
// - Duty wider than the period leaves the output unchanged.
`timescale 1ns/100ps
module tbpwm_top (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // Avalon-MM slave
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // PWM outputs
  output logic             pwm5_out,
  output logic             pwm6_out
);

  // Bus slave state.
  tbpwm_pkg::tbpwm_bus_state_t bus_state;
  tbpwm_pkg::tbpwm_bus_state_t next_bus_state;
  logic        next_waitrequest;
  logic [31:0] next_readdata;
  logic        wr_hit;
  logic [7:0]  wr_byte;

  // Channel control state.
  logic       ch5_enable;
  logic       ch5_polarity;
  logic       ch6_enable;
  logic       ch6_polarity;
  logic       next_ch5_enable;
  logic       next_ch5_polarity;
  logic       next_ch6_enable;
  logic       next_ch6_polarity;

  // Duty registers, kept through reset.
  logic [7:0] ch5_duty_high;
  logic [1:0] ch5_duty_low;
  logic [7:0] ch6_duty_high;
  logic [1:0] ch6_duty_low;
  logic [7:0] next_ch5_duty_high;
  logic [1:0] next_ch5_duty_low;
  logic [7:0] next_ch6_duty_high;
  logic [1:0] next_ch6_duty_low;

  // Period timer state.
  logic [7:0] period_register;
  logic [7:0] period_timer_count;
  logic [5:0] presc_count;
  logic       timer_on;
  logic       period_match_flag;
  tbpwm_pkg::tbpwm_prescale_t timer_prescale_select;
  logic [7:0] next_period_register;
  logic [7:0] next_period_timer_count;
  logic [5:0] next_presc_count;
  logic       next_timer_on;
  logic       next_period_match_flag;
  tbpwm_pkg::tbpwm_prescale_t next_timer_prescale_select;
  logic [5:0] presc_last;
  logic       timer_tick;
  logic       period_match;
  logic [1:0] phase_bits;
  logic [9:0] time_base;

  // Bus handshake: one wait cycle, then the access completes.
  always_comb begin
    next_bus_state   = bus_state;
    next_waitrequest = 1'b1;
    case (bus_state)
      tbpwm_pkg::TBPWM_BUS_IDLE: begin
        if (avs_read || avs_write) begin
          next_bus_state   = tbpwm_pkg::TBPWM_BUS_ACK;
          next_waitrequest = 1'b0;
        end
      end
      tbpwm_pkg::TBPWM_BUS_ACK: begin
        next_bus_state   = tbpwm_pkg::TBPWM_BUS_IDLE;
        next_waitrequest = 1'b1;
      end
      default: begin
        next_bus_state   = tbpwm_pkg::TBPWM_BUS_IDLE;
        next_waitrequest = 1'b1;
      end
    endcase
  end

  // A write takes effect only in the completing cycle on lane zero.
  assign wr_hit  = avs_write && !avs_waitrequest && avs_byteenable[0];
  assign wr_byte = avs_writedata[7:0];

  // Read data is staged during the wait cycle; unmapped reads give zero.
  always_comb begin
    next_readdata = 32'h0000_0000;
    if (avs_read && (bus_state == tbpwm_pkg::TBPWM_BUS_IDLE)) begin
      case (avs_address)
        tbpwm_pkg::TBPWM_CH5_CONTROL_OFS: begin
          next_readdata[7:0] = tbpwm_pkg::tbpwm_ctrl_word(ch5_enable, pwm5_out,
                                                          ch5_polarity);
        end
        tbpwm_pkg::TBPWM_CH5_DUTY_HIGH_OFS: begin
          next_readdata[7:0] = ch5_duty_high;
        end
        tbpwm_pkg::TBPWM_CH5_DUTY_LOW_OFS: begin
          next_readdata[7:0] = {ch5_duty_low, 6'h00};
        end
        tbpwm_pkg::TBPWM_CH6_CONTROL_OFS: begin
          next_readdata[7:0] = tbpwm_pkg::tbpwm_ctrl_word(ch6_enable, pwm6_out,
                                                          ch6_polarity);
        end
        tbpwm_pkg::TBPWM_CH6_DUTY_HIGH_OFS: begin
          next_readdata[7:0] = ch6_duty_high;
        end
        tbpwm_pkg::TBPWM_CH6_DUTY_LOW_OFS: begin
          next_readdata[7:0] = {ch6_duty_low, 6'h00};
        end
        tbpwm_pkg::TBPWM_TIMER_CONTROL_OFS: begin
          next_readdata[7:0] = {5'h00, timer_on, timer_prescale_select};
        end
        tbpwm_pkg::TBPWM_PERIOD_OFS: begin
          next_readdata[7:0] = period_register;
        end
        tbpwm_pkg::TBPWM_TIMER_COUNT_OFS: begin
          next_readdata[7:0] = period_timer_count;
        end
        tbpwm_pkg::TBPWM_STATUS_OFS: begin
          next_readdata[7:0] = {7'h00, period_match_flag};
        end
        default: begin
          next_readdata = 32'h0000_0000;
        end
      endcase
    end
  end

  // Bus registers.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      bus_state       <= tbpwm_pkg::TBPWM_BUS_IDLE;
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
    end else begin
      bus_state       <= next_bus_state;
      avs_waitrequest <= next_waitrequest;
      avs_readdata    <= next_readdata;
    end
  end

  // Channel control writes; the output level bit is read-only.
  always_comb begin
    next_ch5_enable   = ch5_enable;
    next_ch5_polarity = ch5_polarity;
    next_ch6_enable   = ch6_enable;
    next_ch6_polarity = ch6_polarity;
    if (wr_hit && (avs_address == tbpwm_pkg::TBPWM_CH5_CONTROL_OFS)) begin
      next_ch5_enable   = wr_byte[tbpwm_pkg::TBPWM_CTRL_EN_BIT];
      next_ch5_polarity = wr_byte[tbpwm_pkg::TBPWM_CTRL_POL_BIT];
    end
    if (wr_hit && (avs_address == tbpwm_pkg::TBPWM_CH6_CONTROL_OFS)) begin
      next_ch6_enable   = wr_byte[tbpwm_pkg::TBPWM_CTRL_EN_BIT];
      next_ch6_polarity = wr_byte[tbpwm_pkg::TBPWM_CTRL_POL_BIT];
    end
  end

  // Control registers clear on any reset.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ch5_enable   <= tbpwm_pkg::TBPWM_CTRL_RESET[tbpwm_pkg::TBPWM_CTRL_EN_BIT];
      ch5_polarity <= tbpwm_pkg::TBPWM_CTRL_RESET[tbpwm_pkg::TBPWM_CTRL_POL_BIT];
      ch6_enable   <= tbpwm_pkg::TBPWM_CTRL_RESET[tbpwm_pkg::TBPWM_CTRL_EN_BIT];
      ch6_polarity <= tbpwm_pkg::TBPWM_CTRL_RESET[tbpwm_pkg::TBPWM_CTRL_POL_BIT];
    end else begin
      ch5_enable   <= next_ch5_enable;
      ch5_polarity <= next_ch5_polarity;
      ch6_enable   <= next_ch6_enable;
      ch6_polarity <= next_ch6_polarity;
    end
  end

  // Duty writes; bits five to zero of the low register are dropped.
  always_comb begin
    next_ch5_duty_high = ch5_duty_high;
    next_ch5_duty_low  = ch5_duty_low;
    next_ch6_duty_high = ch6_duty_high;
    next_ch6_duty_low  = ch6_duty_low;
    if (wr_hit) begin
      case (avs_address)
        tbpwm_pkg::TBPWM_CH5_DUTY_HIGH_OFS: begin
          next_ch5_duty_high = wr_byte;
        end
        tbpwm_pkg::TBPWM_CH5_DUTY_LOW_OFS: begin
          next_ch5_duty_low = wr_byte[tbpwm_pkg::TBPWM_DUTY_LOW_MSB:
                                      tbpwm_pkg::TBPWM_DUTY_LOW_LSB];
        end
        tbpwm_pkg::TBPWM_CH6_DUTY_HIGH_OFS: begin
          next_ch6_duty_high = wr_byte;
        end
        tbpwm_pkg::TBPWM_CH6_DUTY_LOW_OFS: begin
          next_ch6_duty_low = wr_byte[tbpwm_pkg::TBPWM_DUTY_LOW_MSB:
                                      tbpwm_pkg::TBPWM_DUTY_LOW_LSB];
        end
        default: begin
          next_ch5_duty_high = ch5_duty_high;
        end
      endcase
    end
  end

  // Duty registers have no reset so they survive every reset.
  always_ff @(posedge core_clk) begin
    ch5_duty_high <= next_ch5_duty_high;
    ch5_duty_low  <= next_ch5_duty_low;
    ch6_duty_high <= next_ch6_duty_high;
    ch6_duty_low  <= next_ch6_duty_low;
  end

  // Prescaler end count and the two low time base bits per ratio.
  always_comb begin
    case (timer_prescale_select)
      tbpwm_pkg::TBPWM_PRE1: begin
        presc_last = tbpwm_pkg::TBPWM_LAST_PRE1;
        phase_bits = presc_count[1:0];
      end
      tbpwm_pkg::TBPWM_PRE4: begin
        presc_last = tbpwm_pkg::TBPWM_LAST_PRE4;
        phase_bits = presc_count[3:2];
      end
      default: begin
        presc_last = tbpwm_pkg::TBPWM_LAST_PRE16;
        phase_bits = presc_count[5:4];
      end
    endcase
  end

  // The timer steps once per prescaled cycle and wraps after the period.
  assign timer_tick   = timer_on && (presc_count >= presc_last);
  assign period_match = timer_tick && (period_timer_count == period_register);
  assign time_base    = {period_timer_count, phase_bits};

  // Next timer, period and flag values; a hardware set beats the clear.
  always_comb begin
    next_presc_count           = presc_count;
    next_period_timer_count    = period_timer_count;
    next_period_register       = period_register;
    next_timer_on              = timer_on;
    next_timer_prescale_select = timer_prescale_select;
    next_period_match_flag     = period_match_flag;
    if (!timer_on) begin
      next_presc_count = tbpwm_pkg::TBPWM_PRESC_RESET;
    end else if (timer_tick) begin
      next_presc_count = tbpwm_pkg::TBPWM_PRESC_RESET;
    end else begin
      next_presc_count = presc_count + 6'h01;
    end
    if (period_match) begin
      next_period_timer_count = tbpwm_pkg::TBPWM_COUNT_RESET;
    end else if (timer_tick) begin
      next_period_timer_count = period_timer_count + 8'h01;
    end
    if (wr_hit && (avs_address == tbpwm_pkg::TBPWM_TIMER_COUNT_OFS)) begin
      next_period_timer_count = wr_byte;
    end
    if (wr_hit && (avs_address == tbpwm_pkg::TBPWM_PERIOD_OFS)) begin
      next_period_register = wr_byte;
    end
    if (wr_hit && (avs_address == tbpwm_pkg::TBPWM_TIMER_CONTROL_OFS)) begin
      next_timer_on = wr_byte[tbpwm_pkg::TBPWM_TIMER_ON_BIT];
      case (wr_byte[tbpwm_pkg::TBPWM_PRESCALE_MSB:0])
        2'b00:   next_timer_prescale_select = tbpwm_pkg::TBPWM_PRE1;
        2'b01:   next_timer_prescale_select = tbpwm_pkg::TBPWM_PRE4;
        default: next_timer_prescale_select = tbpwm_pkg::TBPWM_PRE16;
      endcase
    end
    if (wr_hit && (avs_address == tbpwm_pkg::TBPWM_STATUS_OFS) &&
        wr_byte[tbpwm_pkg::TBPWM_MATCH_BIT]) begin
      next_period_match_flag = 1'b0;
    end
    if (period_match) begin
      next_period_match_flag = 1'b1;
    end
  end

  // Timer registers.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      presc_count           <= tbpwm_pkg::TBPWM_PRESC_RESET;
      period_timer_count    <= tbpwm_pkg::TBPWM_COUNT_RESET;
      period_register       <= tbpwm_pkg::TBPWM_PERIOD_RESET;
      timer_on              <= 1'b0;
      timer_prescale_select <= tbpwm_pkg::TBPWM_PRE1;
      period_match_flag     <= 1'b0;
    end else begin
      presc_count           <= next_presc_count;
      period_timer_count    <= next_period_timer_count;
      period_register       <= next_period_register;
      timer_on              <= next_timer_on;
      timer_prescale_select <= next_timer_prescale_select;
      period_match_flag     <= next_period_match_flag;
    end
  end

  // Channel five.
  tbpwm_channel u_ch5 (
    .core_clk        (core_clk),
    .rst             (rst),
    .enable          (ch5_enable),
    .polarity        (ch5_polarity),
    .duty_value      (tbpwm_pkg::tbpwm_duty_join(ch5_duty_high, ch5_duty_low)),
    .load_duty       (period_match),
    .time_base       (time_base),
    .period_register (period_register),
    .pwm_out         (pwm5_out)
  );

  // Channel six.
  tbpwm_channel u_ch6 (
    .core_clk        (core_clk),
    .rst             (rst),
    .enable          (ch6_enable),
    .polarity        (ch6_polarity),
    .duty_value      (tbpwm_pkg::tbpwm_duty_join(ch6_duty_high, ch6_duty_low)),
    .load_duty       (period_match),
    .time_base       (time_base),
    .period_register (period_register),
    .pwm_out         (pwm6_out)
  );

endmodule

// ==== testbench/tbpwm_checker.sv ====
/*
  Checker for the dual PWM block: bus handshake timing and the layout of
  read data. Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/100ps
module tbpwm_checker (
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        rst,
  // Register bus
  input wire logic [7:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  // PWM outputs
  input wire logic        pwm5_out,
  input wire logic        pwm6_out
);
  // Every property runs on the core clock and is void during reset.
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  // Completing reads and the kind of register they address.
  logic rd_done;
  logic is_ctrl;
  logic is_low;
  assign rd_done = avs_read && !avs_waitrequest;
  assign is_ctrl = avs_address == tbpwm_pkg::TBPWM_CH5_CONTROL_OFS ||
                   avs_address == tbpwm_pkg::TBPWM_CH6_CONTROL_OFS;
  assign is_low  = avs_address == tbpwm_pkg::TBPWM_CH5_DUTY_LOW_OFS ||
                   avs_address == tbpwm_pkg::TBPWM_CH6_DUTY_LOW_OFS;

  // The slave answers one cycle after a request and only for one cycle.
  a_wait_answer: assert property ($rose(avs_read || avs_write) |=> !avs_waitrequest)
    else $error("waitrequest did not drop one cycle after the request");
  a_wait_once: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest stayed low for more than one cycle");
  a_wait_cause: assert property (!avs_waitrequest |-> $past(avs_read || avs_write))
    else $error("waitrequest dropped without a request");

  // Read data layout of all reads, the channel registers and unmapped addresses.
  a_upper_zero: assert property (rd_done |-> avs_readdata[31:8] == 24'h00_0000)
    else $error("read data above bit 7 not zero");
  a_low_unused: assert property (rd_done && is_low |-> avs_readdata[5:0] == 6'h00)
    else $error("unused duty low bits not zero");
  a_ctrl_unused: assert property (rd_done && is_ctrl |->
    avs_readdata[6] == 1'b0 && avs_readdata[3:0] == 4'h0)
    else $error("unused control bits not zero");
  a_out_level: assert property (rd_done && is_ctrl |-> avs_readdata[5] ==
    (avs_address == tbpwm_pkg::TBPWM_CH5_CONTROL_OFS ? $past(pwm5_out) : $past(pwm6_out)))
    else $error("output level bit differs from the output");
  a_unmapped_zero: assert property (rd_done && avs_address >= 8'h28 |->
    avs_readdata == 32'h0000_0000)
    else $error("unmapped read not zero");
endmodule

// ==== testbench/tbpwm_tb_top.sv ====
/*
  Self-checking bench for the dual PWM block: register access over
  Avalon-MM and waveform counts on both outputs. Assumes a 50 MHz clock.
*/
`timescale 1ns/100ps
module tbpwm_tb_top;
  // Block ports and bench state.
  logic        core_clk;
  logic        rst;
  logic [7:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        pwm5_out;
  logic        pwm6_out;
  logic [31:0] q;
  int          errors;
  int          checks_done;
  int          cycles;
  int          hi5;
  int          hi6;

  tbpwm_top tbpwm_top_i (
    .core_clk(core_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .pwm5_out(pwm5_out), .pwm6_out(pwm6_out));

  // A 20 ns clock.
  initial core_clk = 1'b0;
  always #10 core_clk = ~core_clk;

  // A hang ends the run as a mismatch.
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      errors = errors + 1;
      test_done();
    end
  end

  // Prints the verdict and stops.
  task automatic test_done();
    if (errors == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Compares one value and reports a mismatch.
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks_done = checks_done + 1;
    if (got !== exp) begin
      errors = errors + 1;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  // One bus access, held until waitrequest is sampled low.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] be);
    @(posedge core_clk);
    avs_address    <= a;
    avs_writedata  <= d;
    avs_byteenable <= be;
    avs_read       <= ~wr;
    avs_write      <= wr;
    do begin
      @(posedge core_clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask

  // Register write and checked register read.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, {24'h00_0000, d}, 4'h1);
  endtask
  task automatic rd(input string name, input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, a, 32'h0000_0000, 4'h1);
    chk(name, {24'h00_0000, e}, q);
  endtask

  // Stops the timer, clears its count and loads period and both duty values.
  task automatic setup(input logic [7:0] per, input logic [9:0] duty);
    wr(tbpwm_pkg::TBPWM_TIMER_CONTROL_OFS, 8'h00);
    wr(tbpwm_pkg::TBPWM_TIMER_COUNT_OFS, 8'h00);
    wr(tbpwm_pkg::TBPWM_PERIOD_OFS, per);
    wr(tbpwm_pkg::TBPWM_CH5_DUTY_HIGH_OFS, duty[9:2]);
    wr(tbpwm_pkg::TBPWM_CH5_DUTY_LOW_OFS, {duty[1:0], 6'h00});
    wr(tbpwm_pkg::TBPWM_CH6_DUTY_HIGH_OFS, duty[9:2]);
    wr(tbpwm_pkg::TBPWM_CH6_DUTY_LOW_OFS, {duty[1:0], 6'h00});
  endtask

  // Starts the timer with a prescale code and lets it run n cycles.
  task automatic go(input logic [1:0] ps, input int n);
    wr(tbpwm_pkg::TBPWM_TIMER_CONTROL_OFS, {5'h00, 1'b1, ps});
    repeat (n) @(posedge core_clk);
  endtask

  // Counts the cycles in which each output is high.
  task automatic measure(input int n);
    hi5 = 0;
    hi6 = 0;
    repeat (n) begin
      @(negedge core_clk);
      if ($isunknown({pwm5_out, pwm6_out})) begin
        errors = errors + 1;
        $display("Error pwm outputs expected known seen %b", {pwm5_out, pwm6_out});
      end
      hi5 = hi5 + ((pwm5_out === 1'b1) ? 1 : 0);
      hi6 = hi6 + ((pwm6_out === 1'b1) ? 1 : 0);
    end
  endtask

  // Main sequence.
  initial begin
    logic [7:0] b;
    int         r;
    rst = 1'b1;
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    avs_byteenable = 4'h1;
    errors = 0;
    checks_done = 0;
    cycles = 0;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    rd("ch5 control", tbpwm_pkg::TBPWM_CH5_CONTROL_OFS, 8'h00);
    rd("ch6 control", tbpwm_pkg::TBPWM_CH6_CONTROL_OFS, 8'h00);
    rd("period", tbpwm_pkg::TBPWM_PERIOD_OFS, 8'hFF);
    // Fields of both channels, duty low and control written as all ones.
    for (int i = 0; i < 2; i++) begin
      b = (i == 0) ? 8'h00 : 8'h0C;
      wr(b + 8'h04, 8'hA5 ^ b);
      wr(b + 8'h08, 8'hFF);
      wr(b, 8'hFF);
      rd("duty high", b + 8'h04, 8'hA5 ^ b);
      rd("duty low", b + 8'h08, 8'hC0);
      rd("control", b, 8'hB0);
      wr(b, 8'hEF);
      rd("control", b, 8'h80);
      wr(b, 8'h00);
    end
    // A reset in mid-run keeps the duty registers.
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    rd("duty high", tbpwm_pkg::TBPWM_CH6_DUTY_HIGH_OFS, 8'hA9);
    rd("duty low", tbpwm_pkg::TBPWM_CH5_DUTY_LOW_OFS, 8'hC0);
    // Masked and unmapped writes change nothing.
    bus(1'b1, tbpwm_pkg::TBPWM_CH5_DUTY_HIGH_OFS, 32'h0000_005A, 4'h0);
    wr(8'h28, 8'h77);
    rd("unmapped", 8'h28, 8'h00);
    rd("duty high", tbpwm_pkg::TBPWM_CH5_DUTY_HIGH_OFS, 8'hA5);
    // Each prescale ratio; channel 6 is active low.
    wr(tbpwm_pkg::TBPWM_CH5_CONTROL_OFS, 8'h80);
    wr(tbpwm_pkg::TBPWM_CH6_CONTROL_OFS, 8'h90);
    for (int i = 0; i < 3; i++) begin
      r = 1 << (2 * i);
      setup(8'h01, 10'h003);
      go(i[1:0], 16 * r);
      measure(16 * r);
      chk("pwm5 highs", 6 * r, hi5);
      chk("pwm6 highs", 10 * r, hi6);
    end
    // A new duty value waits for the period match.
    setup(8'hFF, 10'h000);
    chk("pwm5 held", 32'h0000_0001, 32'(pwm5_out));
    go(2'b00, 1100);
    measure(16);
    chk("pwm5 highs", 0, hi5);
    // Full ten-bit resolution with an odd duty value.
    setup(8'hFF, 10'h201);
    go(2'b00, 1100);
    measure(1024);
    chk("pwm5 highs", 513, hi5);
    // The match flag is set by the wraps above and clears on a written one.
    rd("status", tbpwm_pkg::TBPWM_STATUS_OFS, 8'h01);
    wr(tbpwm_pkg::TBPWM_STATUS_OFS, 8'h01);
    rd("status", tbpwm_pkg::TBPWM_STATUS_OFS, 8'h00);
    // Duty beyond the period holds the low level; equal to it is full on.
    setup(8'h00, 10'h000);
    go(2'b00, 20);
    setup(8'h00, 10'h008);
    go(2'b00, 20);
    measure(16);
    chk("pwm5 highs", 0, hi5);
    setup(8'h00, 10'h004);
    go(2'b00, 20);
    measure(16);
    chk("pwm5 highs", 16, hi5);
    // An oversized duty value also holds a high level.
    setup(8'h00, 10'h008);
    go(2'b00, 20);
    measure(16);
    chk("pwm5 held high", 16, hi5);
    test_done();
  end
endmodule

bind tbpwm_top tbpwm_checker tbpwm_checker_i (
  .core_clk(core_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .pwm5_out(pwm5_out), .pwm6_out(pwm6_out));
